// ==== src/pwsc_map.vh ====
// constants and register map of the sector-write task-file block
// Contract
// - opcodes 30h/31h both write; retry bit ignored
// - sector count zero means 256 sectors
// - sector data moves as 16-bit words
// - address registers hold LBA or CHS fields
// - count left shows sectors not written
// - address left at last sector transferred
// - uncorrectable error stops write at failing sector
// - busy within 400 ns of opcode write (write opcodes go straight to DRQ the next cycle; busy stays clear)
// - busy within 5 us after 256th word
// - data-out: busy clear, ready, interrupt within 30 s
// - data-in: busy clear, request, interrupt within 30 s
// - busy within 10 us after 256th read
// - busy within 400 ns of bus reset
// - busy within 400 ns of software reset
`ifndef PWSC_MAP_VH
`define PWSC_MAP_VH
// register byte offsets
`define PWSC_OFF_DATA 8'h00
`define PWSC_OFF_ERRFEAT 8'h04
`define PWSC_OFF_COUNT 8'h08
`define PWSC_OFF_SECNUM 8'h0C
`define PWSC_OFF_CYLLO 8'h10
`define PWSC_OFF_CYLHI 8'h14
`define PWSC_OFF_DEVHEAD 8'h18
`define PWSC_OFF_STATCMD 8'h1C
`define PWSC_OFF_DEVCTL 8'h20
`define PWSC_OFF_ALTSTAT 8'h24
// opcodes
`define PWSC_OP_WRITE 8'h30
`define PWSC_OP_READ 8'h20
`define PWSC_OP_RETRY_MASK 8'hFE
// status bits
`define PWSC_ST_BUSY 7
`define PWSC_ST_RDY 6
`define PWSC_ST_DF 5
`define PWSC_ST_DSC 4
`define PWSC_ST_DRQ 3
`define PWSC_ST_ERR 0
// error bits
`define PWSC_ER_IDN 4
`define PWSC_ER_ABT 2
// device/head and device control bits
`define PWSC_DH_LBA 6
`define PWSC_DC_SRST 2
`define PWSC_DC_NIEN 1
// reset values
`define PWSC_RST_COUNT 8'h01
`define PWSC_RST_SECNUM 8'h01
`define PWSC_RST_DEVHEAD 8'hA0
// transfer sizes and geometry
`define PWSC_WORD_LAST 8'hFF
`define PWSC_MAX_SECT 9'h100
`define PWSC_SPT 8'h3F
`define PWSC_HEADS 4'hF
`define PWSC_FIFO_DEPTH 16
`define PWSC_INIT_CYC 32'h00000010
// bus answers
`define PWSC_RESP_OKAY 2'h0
`define PWSC_RESP_DECERR 2'h3
// timing
`define PWSC_CLK_NS 8
`define PWSC_CLK_HZ 32'd125000000
`define PWSC_T_CMD_BSY_NS 400
`define PWSC_T_RST_BSY_NS 400
`define PWSC_T_DOUT_BSY_NS 5000
`define PWSC_T_DIN_BSY_NS 10000
`define PWSC_T_CMPL_S 30
`define PWSC_T_READY_S 31
`define PWSC_CMPL_CYC (`PWSC_T_CMPL_S * `PWSC_CLK_HZ)
`endif

// ==== src/pwsc_fifo.v ====
// word fifo between data register and media port
`timescale 1ns/100ps
module pwsc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  input wire flush,
  // fill side
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  // drain side
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] memReg [0:DEPTH-1];
  reg [AW-1:0] wrPtrReg;
  reg [AW-1:0] rdPtrReg;
  reg [AW:0] countReg;
  wire push;
  wire pop;

  assign inReady = (countReg != DEPTH[AW:0]);
  assign outValid = (countReg != {(AW+1){1'b0}});
  assign outData = memReg[rdPtrReg];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge mclk)
  begin
    if (push)
      memReg[wrPtrReg] <= inData;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtrReg <= {AW{1'b0}};
      rdPtrReg <= {AW{1'b0}};
      countReg <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtrReg <= {AW{1'b0}};
      rdPtrReg <= {AW{1'b0}};
      countReg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wrPtrReg <= (wrPtrReg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtrReg + 1'b1;
      if (pop)
        rdPtrReg <= (rdPtrReg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtrReg + 1'b1;
      if (push && !pop)
        countReg <= countReg + 1'b1;
      else if (pop && !push)
        countReg <= countReg - 1'b1;
    end
  end
endmodule

// ==== src/pwsc_top.v ====
// task-file register block with pio sector write and read
`timescale 1ns/100ps
`include "pwsc_map.vh"
module pwsc_top #(
  parameter [31:0] TIMEOUT_CYC = `PWSC_CMPL_CYC,
  parameter [31:0] INIT_CYC = `PWSC_INIT_CYC,
  parameter FIFO_DEPTH = `PWSC_FIFO_DEPTH
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // bus pins
  input wire busReset_b,
  output reg intrqReg,
  // media side
  output wire [15:0] mediaWrData,
  output wire mediaWrValid,
  input wire mediaWrReady,
  input wire [15:0] mediaRdData,
  output reg mediaRdStrobeReg,
  output reg mediaStartReg,
  output reg mediaWriteReg,
  output reg [27:0] mediaAddrReg,
  output reg mediaLbaModeReg,
  input wire mediaDone,
  input wire mediaFail,
  input wire mediaIdnf
);
  localparam [5:0] ST_INIT = 6'h01;
  localparam [5:0] ST_IDLE = 6'h02;
  localparam [5:0] ST_WDRQ = 6'h04;
  localparam [5:0] ST_WBUSY = 6'h08;
  localparam [5:0] ST_RFETCH = 6'h10;
  localparam [5:0] ST_RDRQ = 6'h20;

  reg [5:0] stateReg;
  reg [7:0] featureReg;
  reg [7:0] countReg;
  reg [7:0] secNumReg;
  reg [7:0] cylLowReg;
  reg [7:0] cylHighReg;
  reg [7:0] devHeadReg;
  reg [7:0] errorReg;
  reg errFlagReg;
  reg readyFlagReg;
  reg srstReg;
  reg nienReg;
  reg [8:0] remainReg;
  reg [7:0] wordCntReg;
  reg [31:0] timerReg;
  reg irqPendReg;
  reg irqPend_next;
  reg resetSync1Reg;
  reg resetSync2Reg;
  reg resetSync3Reg;
  reg [31:0] rdValue;
  reg [27:0] advAddr;
  wire busyFlag;
  wire drqFlag;
  wire [7:0] statusByte;
  wire [27:0] curAddr;
  wire wrFire;
  wire rdFire;
  wire wrGo;
  wire rdGo;
  wire wrIsData;
  wire wrLow;
  wire fifoInReady;
  wire fifoPush;
  reg hardResetReg;
  wire statusRead;
  wire dataRead;
  wire timeUp;
  wire irqSet;

  // address decode, used only for the answer code
  function mappedAddr;
    input [7:0] a;
    begin
      mappedAddr = (a[1:0] == 2'h0) && (a <= `PWSC_OFF_ALTSTAT);
    end
  endfunction

  // next sector address in lba or chs form
  function [27:0] nextAddr;
    input lba;
    input [27:0] a;
    begin
      if (lba)
        nextAddr = a + 28'h0000001;
      else if (a[7:0] < `PWSC_SPT)
        nextAddr = {a[27:8], a[7:0] + 8'h01};
      else if (a[27:24] < `PWSC_HEADS)
        nextAddr = {a[27:24] + 4'h1, a[23:8], 8'h01};
      else
        nextAddr = {4'h0, a[23:8] + 16'h0001, 8'h01};
    end
  endfunction

  assign curAddr = {devHeadReg[3:0], cylHighReg, cylLowReg, secNumReg};
  assign busyFlag = stateReg[0] | stateReg[3] | stateReg[4];
  assign drqFlag = stateReg[2] | stateReg[5];
  assign statusByte = {busyFlag, readyFlagReg & ~busyFlag, 1'b0, readyFlagReg, drqFlag, 2'h0,
    errFlagReg};
  assign wrFire = s_axi_awready;
  assign rdFire = s_axi_arready;
  assign wrIsData = (s_axi_awaddr == `PWSC_OFF_DATA);
  assign wrLow = s_axi_wstrb[0];
  assign wrGo = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid & (~wrIsData | fifoInReady);
  assign rdGo = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign fifoPush = wrFire & wrIsData & (s_axi_wstrb[1:0] == 2'h3) & stateReg[2];
  assign statusRead = rdFire & (s_axi_araddr == `PWSC_OFF_STATCMD);
  assign dataRead = rdFire & (s_axi_araddr == `PWSC_OFF_DATA) & stateReg[5];
  assign timeUp = (timerReg >= TIMEOUT_CYC - 32'h00000002);
  assign irqSet = (stateReg[3] & (mediaDone | mediaFail | timeUp)) | (stateReg[4] & (mediaDone | mediaFail
    | timeUp)) | (stateReg[5] & dataRead & (wordCntReg == `PWSC_WORD_LAST) & mediaFail);

  pwsc_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_pwsc_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(stateReg[0]),
    .inData(s_axi_wdata[15:0]),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(mediaWrData),
    .outValid(mediaWrValid),
    .outReady(mediaWrReady)
  );

  // bus reset pin synchroniser
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resetSync1Reg <= 1'b0;
      resetSync2Reg <= 1'b0;
      resetSync3Reg <= 1'b0;
      hardResetReg <= 1'b0;
    end
    else
    begin
      resetSync1Reg <= ~busReset_b;
      resetSync2Reg <= resetSync1Reg;
      resetSync3Reg <= resetSync2Reg;
      if (resetSync2Reg == resetSync3Reg)
        hardResetReg <= resetSync3Reg;
    end
  end

  // axi handshake and answers
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWSC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PWSC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      s_axi_awready <= wrGo;
      s_axi_wready <= wrGo;
      s_axi_arready <= rdGo;
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mappedAddr(s_axi_awaddr) ? `PWSC_RESP_OKAY : `PWSC_RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= mappedAddr(s_axi_araddr) ? `PWSC_RESP_OKAY : `PWSC_RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // read mux
  always @*
  begin
    rdValue = 32'h00000000;
    case (s_axi_araddr)
      `PWSC_OFF_DATA: rdValue = stateReg[5] ? {16'h0000, mediaRdData} : 32'h00000000;
      `PWSC_OFF_ERRFEAT: rdValue = {24'h000000, errorReg};
      `PWSC_OFF_COUNT: rdValue = {24'h000000, countReg};
      `PWSC_OFF_SECNUM: rdValue = {24'h000000, secNumReg};
      `PWSC_OFF_CYLLO: rdValue = {24'h000000, cylLowReg};
      `PWSC_OFF_CYLHI: rdValue = {24'h000000, cylHighReg};
      `PWSC_OFF_DEVHEAD: rdValue = {24'h000000, devHeadReg};
      `PWSC_OFF_STATCMD: rdValue = {24'h000000, statusByte};
      `PWSC_OFF_DEVCTL: rdValue = {29'h00000000, srstReg, nienReg, 1'b0};
      `PWSC_OFF_ALTSTAT: rdValue = {24'h000000, statusByte};
      default: rdValue = 32'h00000000;
    endcase
  end

  // interrupt: a new event wins over the status-read clear
  always @*
  begin
    irqPend_next = irqPendReg;
    if (statusRead)
      irqPend_next = 1'b0;
    if (irqSet)
      irqPend_next = 1'b1;
    if (stateReg[0])
      irqPend_next = 1'b0;
    advAddr = nextAddr(devHeadReg[`PWSC_DH_LBA], curAddr);
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqPendReg <= 1'b0;
      intrqReg <= 1'b0;
    end
    else
    begin
      irqPendReg <= irqPend_next;
      intrqReg <= irqPend_next & ~nienReg;
    end
  end

  // command engine and task-file registers
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateReg <= ST_INIT;
      featureReg <= 8'h00;
      countReg <= `PWSC_RST_COUNT;
      secNumReg <= `PWSC_RST_SECNUM;
      cylLowReg <= 8'h00;
      cylHighReg <= 8'h00;
      devHeadReg <= `PWSC_RST_DEVHEAD;
      errorReg <= 8'h00;
      errFlagReg <= 1'b0;
      readyFlagReg <= 1'b0;
      srstReg <= 1'b0;
      nienReg <= 1'b0;
      remainReg <= 9'h000;
      wordCntReg <= 8'h00;
      timerReg <= 32'h00000000;
      mediaStartReg <= 1'b0;
      mediaWriteReg <= 1'b0;
      mediaRdStrobeReg <= 1'b0;
      mediaAddrReg <= 28'h0000000;
      mediaLbaModeReg <= 1'b0;
    end
    else
    begin
      mediaStartReg <= 1'b0;
      mediaRdStrobeReg <= dataRead;
      if (wrFire && wrLow && (s_axi_awaddr == `PWSC_OFF_DEVCTL))
      begin
        srstReg <= s_axi_wdata[`PWSC_DC_SRST];
        nienReg <= s_axi_wdata[`PWSC_DC_NIEN];
      end
      if (hardResetReg || srstReg)
      begin
        stateReg <= ST_INIT;
        timerReg <= 32'h00000000;
        readyFlagReg <= 1'b0;
        errFlagReg <= 1'b0;
        errorReg <= 8'h00;
        countReg <= `PWSC_RST_COUNT;
        secNumReg <= `PWSC_RST_SECNUM;
        cylLowReg <= 8'h00;
        cylHighReg <= 8'h00;
        devHeadReg <= `PWSC_RST_DEVHEAD;
      end
      else
      begin
        case (stateReg)
          ST_INIT:
          begin
            timerReg <= timerReg + 32'h00000001;
            if (timerReg >= INIT_CYC)
            begin
              stateReg <= ST_IDLE;
              readyFlagReg <= 1'b1;
              timerReg <= 32'h00000000;
            end
          end
          ST_IDLE:
          begin
            if (wrFire && wrLow)
            begin
              case (s_axi_awaddr)
                `PWSC_OFF_ERRFEAT: featureReg <= s_axi_wdata[7:0];
                `PWSC_OFF_COUNT: countReg <= s_axi_wdata[7:0];
                `PWSC_OFF_SECNUM: secNumReg <= s_axi_wdata[7:0];
                `PWSC_OFF_CYLLO: cylLowReg <= s_axi_wdata[7:0];
                `PWSC_OFF_CYLHI: cylHighReg <= s_axi_wdata[7:0];
                `PWSC_OFF_DEVHEAD: devHeadReg <= s_axi_wdata[7:0];
                `PWSC_OFF_STATCMD:
                begin
                  errorReg <= 8'h00;
                  errFlagReg <= 1'b0;
                  wordCntReg <= 8'h00;
                  timerReg <= 32'h00000000;
                  remainReg <= (countReg == 8'h00) ? `PWSC_MAX_SECT : {1'b0, countReg};
                  mediaAddrReg <= curAddr;
                  mediaLbaModeReg <= devHeadReg[`PWSC_DH_LBA];
                  if ((s_axi_wdata[7:0] & `PWSC_OP_RETRY_MASK) == `PWSC_OP_WRITE)
                  begin
                    stateReg <= ST_WDRQ;
                    mediaWriteReg <= 1'b1;
                    mediaStartReg <= 1'b1;
                  end
                  else if ((s_axi_wdata[7:0] & `PWSC_OP_RETRY_MASK) == `PWSC_OP_READ)
                  begin
                    stateReg <= ST_RFETCH;
                    mediaWriteReg <= 1'b0;
                    mediaStartReg <= 1'b1;
                  end
                  else
                  begin
                    errFlagReg <= 1'b1;
                    errorReg <= 8'h01 << `PWSC_ER_ABT;
                    stateReg <= ST_RFETCH;
                    timerReg <= TIMEOUT_CYC;
                  end
                end
                default: featureReg <= featureReg;
              endcase
            end
          end
          ST_WDRQ:
          begin
            if (mediaFail)
            begin
              stateReg <= ST_WBUSY;
              timerReg <= TIMEOUT_CYC;
            end
            else if (fifoPush)
            begin
              wordCntReg <= wordCntReg + 8'h01;
              if (wordCntReg == `PWSC_WORD_LAST)
              begin
                stateReg <= ST_WBUSY;
                timerReg <= 32'h00000000;
              end
            end
          end
          ST_WBUSY:
          begin
            timerReg <= timerReg + 32'h00000001;
            if (mediaFail || timeUp)
            begin
              stateReg <= ST_IDLE;
              errFlagReg <= 1'b1;
              errorReg <= 8'h01 << ((mediaFail && mediaIdnf) ? `PWSC_ER_IDN : `PWSC_ER_ABT);
              countReg <= remainReg[7:0];
            end
            else if (mediaDone)
            begin
              remainReg <= remainReg - 9'h001;
              countReg <= remainReg[7:0] - 8'h01;
              wordCntReg <= 8'h00;
              timerReg <= 32'h00000000;
              if (remainReg == 9'h001)
                stateReg <= ST_IDLE;
              else
              begin
                {devHeadReg[3:0], cylHighReg, cylLowReg, secNumReg} <= advAddr;
                mediaAddrReg <= advAddr;
                mediaStartReg <= 1'b1;
                stateReg <= ST_WDRQ;
              end
            end
          end
          ST_RFETCH:
          begin
            timerReg <= timerReg + 32'h00000001;
            if (mediaFail || timeUp)
            begin
              stateReg <= ST_IDLE;
              errFlagReg <= 1'b1;
              if (!errFlagReg)
                errorReg <= 8'h01 << ((mediaFail && mediaIdnf) ? `PWSC_ER_IDN : `PWSC_ER_ABT);
              countReg <= remainReg[7:0];
            end
            else if (mediaDone)
            begin
              stateReg <= ST_RDRQ;
              wordCntReg <= 8'h00;
            end
          end
          ST_RDRQ:
          begin
            if (dataRead)
            begin
              wordCntReg <= wordCntReg + 8'h01;
              if (wordCntReg == `PWSC_WORD_LAST)
              begin
                remainReg <= remainReg - 9'h001;
                countReg <= remainReg[7:0] - 8'h01;
                timerReg <= 32'h00000000;
                if (mediaFail || remainReg == 9'h001)
                  stateReg <= ST_IDLE;
                else
                begin
                  stateReg <= ST_RFETCH;
                  {devHeadReg[3:0], cylHighReg, cylLowReg, secNumReg} <= advAddr;
                  mediaAddrReg <= advAddr;
                  mediaStartReg <= 1'b1;
                end
              end
            end
          end
          default: stateReg <= ST_INIT;
        endcase
      end
    end
  end
endmodule

// ==== tb/pwsc_properties.sv ====
// port-level checker for the task-file block
`timescale 1ns/100ps
module pwsc_properties (
  // clock and reset
  input logic mclk,
  input logic rst_b,
  // register bus
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  // media side
  input logic [15:0] mediaWrData,
  input logic mediaWrValid,
  input logic mediaWrReady,
  input logic mediaRdStrobeReg,
  input logic mediaStartReg,
  input logic mediaWriteReg,
  input logic mediaFail
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_addr_data_together;
    s_axi_awready |-> s_axi_wready;
  endproperty
  a_addr_data_together: assert property (p_addr_data_together) else $error("write channels taken apart");
  property p_bvalid_after_take;
    s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_bvalid_after_take: assert property (p_bvalid_after_take) else $error("write answer late");
  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("second write taken early");
  property p_rvalid_after_take;
    s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rvalid_after_take: assert property (p_rvalid_after_take) else $error("read answer late");
  property p_one_read;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_one_read: assert property (p_one_read) else $error("second read taken early");
  property p_unmapped_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered");
  property p_word_held;
    mediaWrValid && !mediaWrReady |=> mediaWrValid && $stable(mediaWrData);
  endproperty
  a_word_held: assert property (p_word_held) else $error("stalled word lost");
  property p_strobe_after_read;
    mediaRdStrobeReg |-> $past(s_axi_arready) || $past(s_axi_arready, 2);
  endproperty
  a_strobe_after_read: assert property (p_strobe_after_read) else $error("word advance without read");
  property p_fail_stops;
    mediaFail |=> !mediaStartReg [*8];
  endproperty
  a_fail_stops: assert property (p_fail_stops) else $error("sector started after failure");
  c_write_start: cover property (mediaStartReg && mediaWriteReg);
  c_read_start: cover property (mediaStartReg && !mediaWriteReg);
  c_failure: cover property (mediaFail);
endmodule
bind pwsc_top pwsc_properties u_pwsc_properties (.mclk(mclk), .rst_b(rst_b), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .mediaWrData(mediaWrData), .mediaWrValid(mediaWrValid),
  .mediaWrReady(mediaWrReady), .mediaRdStrobeReg(mediaRdStrobeReg), .mediaStartReg(mediaStartReg),
  .mediaWriteReg(mediaWriteReg), .mediaFail(mediaFail));

// ==== tb/pwsc_media_model.sv ====
// media-side partner with start stalls and injectable failure
`timescale 1ns/100ps
module pwsc_media_model (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // media port
  input wire [15:0] mediaWrData,
  input wire mediaWrValid,
  output wire mediaWrReady,
  output wire [15:0] mediaRdData,
  input wire mediaRdStrobeReg,
  input wire mediaStartReg,
  input wire mediaWriteReg,
  input wire [27:0] mediaAddrReg,
  input wire mediaLbaModeReg,
  output reg mediaDone,
  output reg mediaFail,
  output wire mediaIdnf,
  // bench control
  input wire clr,
  input wire idnfMode,
  input wire [7:0] failAt,
  output reg [15:0] wordCnt,
  output reg [7:0] secIdx,
  output reg [27:0] firstAddr,
  output reg firstLba,
  output reg badWord
);
  reg act;
  reg failNow;
  reg [8:0] got;
  reg [15:0] dly;
  reg [15:0] rdWord;
  // stall at sector start so words queue up in the fifo
  assign mediaWrReady = act && dly >= 16'h0028 && got != 9'h100;
  assign mediaRdData = rdWord;
  assign mediaIdnf = idnfMode;
  always @(posedge mclk or negedge rst_b)
    if (!rst_b)
      {act, failNow, got, dly, rdWord, wordCnt, secIdx, firstAddr, firstLba, mediaDone, mediaFail, badWord} <= 0;
    else
    begin
      mediaDone <= 1'b0;
      mediaFail <= 1'b0;
      if (mediaRdStrobeReg)
        rdWord <= rdWord + 16'h0001;
      if (clr)
      begin
        secIdx <= 8'h00;
        wordCnt <= 16'h0000;
        rdWord <= 16'h0000;
      end
      else if (mediaStartReg)
      begin
        act <= 1'b1;
        dly <= 16'h0000;
        got <= 9'h000;
        secIdx <= secIdx + 8'h01;
        failNow <= secIdx + 8'h01 == failAt;
        if (secIdx == 8'h00)
        begin
          firstAddr <= mediaAddrReg;
          firstLba <= mediaLbaModeReg;
        end
      end
      else if (act)
      begin
        dly <= dly + 16'h0001;
        if (mediaWrValid && mediaWrReady)
        begin
          got <= got + 9'h001;
          wordCnt <= wordCnt + 16'h0001;
          if (mediaWrData != {8'h00, got[7:0]})
            badWord <= 1'b1;
          if (got == 9'h0FF)
            dly <= 16'h0000;
        end
        if (dly >= 16'h003C && (!mediaWriteReg || got == 9'h100))
        begin
          act <= 1'b0;
          mediaFail <= failNow;
          mediaDone <= !failNow;
        end
      end
    end
endmodule

// ==== tb/pwsc_bench.sv ====
// register-level bench for the sector-write block
`timescale 1ns/100ps
module pwsc_bench;
  reg mclk, rst_b, busReset_b, clr, idnfMode;
  reg [7:0] failAt, s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, d;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, intrqReg;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] mediaWrData, mediaRdData, wordCnt;
  wire mediaWrValid, mediaWrReady, mediaRdStrobeReg, mediaStartReg, mediaWriteReg, mediaLbaModeReg;
  wire mediaDone, mediaFail, mediaIdnf, firstLba, badWord;
  wire [27:0] mediaAddrReg, firstAddr;
  wire [7:0] secIdx;
  int err_total, samples_checked, s, i, k;
  pwsc_top #(.TIMEOUT_CYC(32'd200)) u_pwsc_top (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .busReset_b(busReset_b), .intrqReg(intrqReg),
    .mediaWrData(mediaWrData), .mediaWrValid(mediaWrValid), .mediaWrReady(mediaWrReady),
    .mediaRdData(mediaRdData), .mediaRdStrobeReg(mediaRdStrobeReg), .mediaStartReg(mediaStartReg),
    .mediaWriteReg(mediaWriteReg), .mediaAddrReg(mediaAddrReg), .mediaLbaModeReg(mediaLbaModeReg),
    .mediaDone(mediaDone), .mediaFail(mediaFail), .mediaIdnf(mediaIdnf));
  pwsc_media_model u_pwsc_media_model (.mclk(mclk), .rst_b(rst_b), .mediaWrData(mediaWrData),
    .mediaWrValid(mediaWrValid), .mediaWrReady(mediaWrReady), .mediaRdData(mediaRdData),
    .mediaRdStrobeReg(mediaRdStrobeReg), .mediaStartReg(mediaStartReg), .mediaWriteReg(mediaWriteReg),
    .mediaAddrReg(mediaAddrReg), .mediaLbaModeReg(mediaLbaModeReg), .mediaDone(mediaDone),
    .mediaFail(mediaFail), .mediaIdnf(mediaIdnf), .clr(clr), .idnfMode(idnfMode), .failAt(failAt),
    .wordCnt(wordCnt), .secIdx(secIdx), .firstAddr(firstAddr), .firstLba(firstLba), .badWord(badWord));
  task wr(input [7:0] a, input [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(posedge mclk);
    while (s_axi_awready !== 1'b1) @(posedge mclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge mclk);
    while (s_axi_bvalid !== 1'b1) @(posedge mclk);
  endtask
  task rd(input [7:0] a, output [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge mclk);
    while (s_axi_arready !== 1'b1) @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    @(posedge mclk);
    while (s_axi_rvalid !== 1'b1) @(posedge mclk);
    v = s_axi_rdata;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked++;
      if (g !== e)
      begin
        err_total++;
        $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    rd(a, d);
    chk({24'h0, d[7:0]}, {24'h0, e});
  endtask
  task waitst(input [7:0] m, input [7:0] v);
    rd(8'h24, d);
    for (int n = 0; n < 3000 && (d[7:0] & m) !== v; n++) rd(8'h24, d);
    chk({24'h0, d[7:0] & m}, {24'h0, v});
  endtask
  task setup(input [7:0] cnt, input [7:0] dh, input [7:0] op);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    wr(8'h08, cnt);
    wr(8'h0C, 8'h10);
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h56);
    wr(8'h18, dh);
    wr(8'h1C, op);
  endtask
  task wsec;
    waitst(8'h88, 8'h08);
    for (i = 0; i < 256; i++) wr(8'h00, i);
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    summarize;
  end
  initial
  begin
    {rst_b, clr, idnfMode, failAt, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, err_total, samples_checked} = 0;
    busReset_b = 1'b1;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdc(8'h08, 8'h01);
    rdc(8'h0C, 8'h01);
    rdc(8'h18, 8'hA0);
    rdc(8'h04, 8'h00);
    waitst(8'hC0, 8'h40);
    rd(8'h28, d);
    chk({d[29:0], s_axi_rresp}, 32'h00000003);
    wr(8'h28, 32'h00000000);
    chk({30'h0, s_axi_bresp}, 32'h00000003);
    for (k = 0; k < 2; k++)
    begin
      setup(8'h02, k ? 8'hA3 : 8'hE3, 8'h30 + k);
      wsec;
      rd(8'h24, d);
      chk(d[7], 1'b1);
      wsec;
      waitst(8'hC8, 8'h40);
      chk(intrqReg, 1'b1);
      rdc(8'h08, 8'h00);
      rdc(8'h0C, 8'h11);
      rdc(8'h14, 8'h56);
      rdc(8'h1C, 8'h50);
      chk(intrqReg, 1'b0);
      chk({firstLba, 3'h0, firstAddr}, {!k[0], 3'h0, 28'h3563410});
      chk(wordCnt, 16'd512);
    end
    setup(8'h02, 8'hE3, 8'h20);
    rd(8'h24, d);
    chk(d[7], 1'b1);
    for (s = 0; s < 2; s++)
    begin
      waitst(8'h88, 8'h08);
      chk(intrqReg, 1'b1);
      rdc(8'h1C, 8'h58);
      for (i = 0; i < 256; i++)
      begin
        rd(8'h00, d);
        chk(d[15:0], s * 256 + i);
      end
      rd(8'h24, d);
      chk(d[7], s == 0);
    end
    failAt <= 8'h02;
    setup(8'h03, 8'hE3, 8'h30);
    wsec;
    wsec;
    waitst(8'h89, 8'h01);
    rdc(8'h1C, 8'h51);
    rdc(8'h04, 8'h04);
    rdc(8'h08, 8'h02);
    rdc(8'h0C, 8'h11);
    chk(secIdx, 8'h02);
    failAt <= 8'h01;
    idnfMode <= 1'b1;
    setup(8'h00, 8'hE3, 8'h31);
    wsec;
    waitst(8'h89, 8'h01);
    rdc(8'h08, 8'h00);
    rdc(8'h04, 8'h10);
    setup(8'h01, 8'hE3, 8'h90);
    waitst(8'h89, 8'h01);
    rdc(8'h04, 8'h04);
    wr(8'h20, 8'h04);
    rd(8'h24, d);
    chk(d[7], 1'b1);
    wr(8'h20, 8'h00);
    waitst(8'hC0, 8'h40);
    busReset_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(8'h24, d);
    chk(d[7], 1'b1);
    busReset_b <= 1'b1;
    waitst(8'hC0, 8'h40);
    chk(badWord, 1'b0);
    summarize;
  end
endmodule
